// ==== include/conv_consts.vh ====
`ifndef CONV_CONSTS_VH
`define CONV_CONSTS_VH
`define CTRL_W          12
`define CTRL_RESET      12'h000
`define BIT_RANGE       0
`define BIT_SEQ_B       1
`define BIT_SEQ_A       2
`define BIT_MODE0       3
`define BIT_MODE1       4
`define BIT_ADDR0       5
`define BIT_ADDR1       6
`define BIT_CODING      9
`define BIT_PM0         10
`define BIT_PM1         11
`define CONV_CYCLES_12  12
`define CONV_CYCLES_10  10
`define PM_AUTO_SHDN    2'h2
`define PM_AUTO_STBY    2'h1
`endif

// ==== src/chan_seq.v ====
`timescale 1ns/10ps
`default_nettype none
`include "conv_consts.vh"
// picks the channel of the next conversion
module chan_seq (
   input  wire       clk,
   input  wire       rstn,
   input  wire       load,
   input  wire [1:0] addr,
   input  wire       seq_a,
   input  wire       seq_b,
   input  wire       step,
   output reg  [1:0] chan_reg
);
   reg  [1:0] last_reg;
   wire       seq_on;
   assign seq_on = seq_a & seq_b;
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         chan_reg <= 2'h0;
         last_reg <= 2'h0;
      end else if (load) begin
         // sequencer from 0 up to addr, else fixed channel
         chan_reg <= seq_on ? 2'h0 : addr;
         last_reg <= addr;
      end else if (step && seq_on) begin
         chan_reg <= (chan_reg == last_reg) ? 2'h0 : chan_reg + 2'h1;
      end
   end
endmodule
`default_nettype wire

// ==== src/conv_ctrl.v ====
`timescale 1ns/10ps
`default_nettype none
`include "conv_consts.vh"
module conv_ctrl #(
   parameter RES12 = 1
) (
   input  wire        clk,
   input  wire        rstn,
   input  wire        conversion_start_n,
   input  wire        cs_n,
   input  wire        rd_n,
   input  wire        wr_n,
   input  wire        word_mode,
   input  wire        high_byte_select,
   input  wire [11:0] data_in,
   input  wire [11:0] sar_code,
   output reg  [11:0] data_out,
   output reg  [11:0] data_oe,
   output reg         busy,
   output reg         track,
   output reg         powered,
   output reg  [1:0]  chan_sel,
   output reg  [1:0]  input_mode,
   output reg         range_2x,
   output reg         twos_comp
);
   localparam [3:0] CYC = RES12 ? `CONV_CYCLES_12 : `CONV_CYCLES_10;
   localparam [1:0] S_IDLE = 2'b01;
   localparam [1:0] S_CONV = 2'b10;

   // true for the two modes that sleep after each conversion
   function is_auto_pm;
      input [1:0] pm;
      begin
         is_auto_pm = (pm == `PM_AUTO_SHDN) || (pm == `PM_AUTO_STBY);
      end
   endfunction

   // coding and justification of the stored result
   function [11:0] fmt_result;
      input [11:0] raw;
      input        coding;
      input        full_width;
      reg   [11:0] coded;
      begin
         coded      = coding ? (raw ^ 12'h800) : raw;
         fmt_result = full_width ? coded : {coded[11:2], 2'b00};
      end
   endfunction

   // word on all twelve lines, or one byte on the low eight
   function [11:0] read_word;
      input        wide;
      input        upper;
      input [11:0] res;
      input [1:0]  id;
      begin
         if (wide) begin
            read_word = res;
         end else if (upper) begin
            read_word = {6'h00, id, res[11:8]};
         end else begin
            read_word = {4'h0, res[7:0]};
         end
      end
   endfunction

   function [11:0] read_lanes;
      input wide;
      begin
         read_lanes = wide ? 12'hFFF : 12'h0FF;
      end
   endfunction

   reg  [1:0]  state_reg;
   reg  [3:0]  cnt_reg;
   reg         start_d_reg;
   reg  [11:0] ctrl_reg;
   reg  [11:0] result_reg;
   reg  [1:0]  res_chan_reg;
   // next values of the state machine and of the read port
   reg  [1:0]  state_next;
   reg  [3:0]  cnt_next;
   reg         busy_next;
   reg         track_next;
   reg  [11:0] data_out_next;
   reg  [11:0] data_oe_next;
   wire        start_fall;
   wire        start_rise;
   wire        wr_hit;
   wire        done;
   wire [1:0]  chan;
   wire [11:0] code;

   assign start_fall = start_d_reg & ~conversion_start_n;
   assign start_rise = ~start_d_reg & conversion_start_n;
   assign wr_hit = ~cs_n & ~wr_n;
   assign done = (state_reg == S_CONV) && (cnt_reg == CYC - 4'h1);
   // twos complement flips the top bit of the straight code
   assign code = fmt_result(sar_code, ctrl_reg[`BIT_CODING], RES12 != 0);

   chan_seq u_seq (
      .clk      (clk),
      .rstn     (rstn),
      .load     (wr_hit),
      .addr     ({data_in[`BIT_ADDR1], data_in[`BIT_ADDR0]}),
      .seq_a    (data_in[`BIT_SEQ_A]),
      .seq_b    (data_in[`BIT_SEQ_B]),
      .step     (done),
      .chan_reg (chan)
   );

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_reg <= `CTRL_RESET;
      end else if (wr_hit) begin
         ctrl_reg <= data_in;
      end
   end

   // idle until a start fall, then counts out the conversion cycles
   always @* begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      busy_next  = busy;
      track_next = track;
      case (state_reg)
         S_IDLE: begin
            if (start_fall) begin
               state_next = S_CONV;
               busy_next  = 1'b1;
               track_next = 1'b0;
               cnt_next   = 4'h0;
            end
         end
         S_CONV: begin
            // further start falls ignored here
            cnt_next = cnt_reg + 4'h1;
            if (cnt_reg == CYC - 4'h2) begin
               track_next = 1'b1;
            end
            if (done) begin
               busy_next  = 1'b0;
               state_next = S_IDLE;
            end
         end
         default: begin
            state_next = S_IDLE;
            busy_next  = 1'b0;
            track_next = 1'b1;
         end
      endcase
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_reg    <= S_IDLE;
         cnt_reg      <= 4'h0;
         start_d_reg  <= 1'b1;
         busy         <= 1'b0;
         track        <= 1'b1;
         result_reg   <= 12'h000;
         res_chan_reg <= 2'h0;
      end else begin
         start_d_reg <= conversion_start_n;
         state_reg   <= state_next;
         cnt_reg     <= cnt_next;
         busy        <= busy_next;
         track       <= track_next;
         if (done) begin
            result_reg   <= code;
            res_chan_reg <= chan;
         end
      end
   end

   // a wake edge outranks the power-down at the end of a conversion
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         powered <= 1'b1;
      end else if (start_rise) begin
         powered <= 1'b1;
      end else if (done && is_auto_pm(ctrl_reg[`BIT_PM1:`BIT_PM0])) begin
         powered <= 1'b0;
      end
   end

   // only results are ever read, never the control register
   always @* begin
      data_out_next = data_out;
      // lines are released one cycle after the strobe lifts
      data_oe_next  = 12'h000;
      if (~cs_n & ~rd_n) begin
         data_out_next = read_word(word_mode, high_byte_select,
                                   result_reg, res_chan_reg);
         data_oe_next  = read_lanes(word_mode);
      end
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         data_out <= 12'h000;
         data_oe  <= 12'h000;
      end else begin
         data_out <= data_out_next;
         data_oe  <= data_oe_next;
      end
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         chan_sel   <= 2'h0;
         input_mode <= 2'h0;
         range_2x   <= 1'b0;
         twos_comp  <= 1'b0;
      end else begin
         chan_sel   <= chan;
         input_mode <= ctrl_reg[`BIT_MODE1:`BIT_MODE0];
         range_2x   <= ~ctrl_reg[`BIT_RANGE];
         twos_comp  <= ctrl_reg[`BIT_CODING];
      end
   end
endmodule
`default_nettype wire

// ==== sim/analog_core_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// stands in for the analog core: settled code for the next conversion
module analog_core_model (
   input  wire logic [11:0] level,
   output logic      [11:0] sar_code
);
   assign sar_code = level;
endmodule
`default_nettype wire

// ==== sim/conv_ctrl_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
module conv_ctrl_monitor #(
   parameter RES12 = 1
) (
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic        conversion_start_n,
   input wire logic        cs_n,
   input wire logic        rd_n,
   input wire logic        wr_n,
   input wire logic        word_mode,
   input wire logic [11:0] data_in,
   input wire logic [11:0] data_oe,
   input wire logic        busy,
   input wire logic        track,
   input wire logic        powered,
   input wire logic [1:0]  input_mode,
   input wire logic        range_2x,
   input wire logic        twos_comp
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   logic [7:0] cnt_reg;
   always @(posedge clk or negedge rstn) begin
      if (!rstn) cnt_reg <= 8'h00;
      else cnt_reg <= busy ? cnt_reg + 8'h01 : 8'h00;
   end
   AST_BUSY_RISE: assert property ($fell(conversion_start_n) && !busy |=> busy)
      else $error("busy did not rise");
   AST_BUSY_LEN: assert property (
      $fell(busy) |-> cnt_reg == (RES12 ? 12 : 10))
      else $error("wrong conversion length");
   AST_TRACK_LATE: assert property ($fell(busy) |-> $past(track) && track)
      else $error("track not back before busy fell");
   AST_HOLD: assert property ($rose(busy) |-> !track ##1 (!track || !busy))
      else $error("not holding at conversion start");
   AST_READ_OE: assert property (word_mode && !cs_n && !rd_n |=> data_oe == 12'hFFF)
      else $error("bus not driven on read");
   AST_OE_OFF: assert property (cs_n || rd_n |=> data_oe == 12'h000)
      else $error("bus driven outside read");
   AST_WRITE: assert property (
      !cs_n && !wr_n |=> ##1 input_mode == $past(data_in[4:3], 2)
      && twos_comp == $past(data_in[9], 2)
      && range_2x != $past(data_in[0], 2))
      else $error("control not captured");
   AST_WAKE: assert property ($rose(conversion_start_n) |-> ##[1:2] powered)
      else $error("no wake on start rise");
   COV_CONV: cover property ($fell(busy));
   COV_READ: cover property (!cs_n && !rd_n);
   COV_SLEEP: cover property ($fell(powered));
endmodule
bind conv_ctrl conv_ctrl_monitor #(.RES12(RES12)) i_mon (.clk(clk), .rstn(rstn),
   .conversion_start_n(conversion_start_n), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
   .word_mode(word_mode), .data_in(data_in), .data_oe(data_oe), .busy(busy),
   .track(track), .powered(powered), .input_mode(input_mode),
   .range_2x(range_2x), .twos_comp(twos_comp));
`default_nettype wire

// ==== sim/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, a) begin check_count++; if ((e) !== (a)) begin mismatches++; \
   $display("Error %s exp %h got %h", nm, e, a); end end
module tb_top;
   logic clk = 0, rstn = 0, st_n = 1, cs_n = 1, rd_n = 1, wr_n = 1, wm = 1, hb = 0;
   logic [11:0] din = 12'h000, lvl = 12'h000, code, dout, oe;
   logic [11:0] rdata;
   logic [1:0]  chan, imode;
   logic        busy, track, pwr, r2x, tc;
   int          mismatches = 0, check_count = 0, n;
   always #2 clk = ~clk;
   analog_core_model i_core (.level(lvl), .sar_code(code));
   conv_ctrl i_dut (.clk(clk), .rstn(rstn), .conversion_start_n(st_n), .cs_n(cs_n),
      .rd_n(rd_n), .wr_n(wr_n), .word_mode(wm), .high_byte_select(hb),
      .data_in(din), .sar_code(code), .data_out(dout), .data_oe(oe), .busy(busy),
      .track(track), .powered(pwr), .chan_sel(chan), .input_mode(imode),
      .range_2x(r2x), .twos_comp(tc));
   task tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task wr(input [11:0] d);
      din = d; cs_n = 0; wr_n = 0; tick(1); cs_n = 1; wr_n = 1; tick(1);
   endtask
   task rd(output [11:0] d);
      cs_n = 0; rd_n = 0; tick(2); d = dout; cs_n = 1; rd_n = 1; tick(1);
   endtask
   task conv(input [11:0] c);
      lvl = c; st_n = 1; tick(1); st_n = 0; tick(2); n = 1;
      while (busy === 1'b1 && n < 40) begin
         n++;
         if (n == 4) st_n = 1;
         if (n == 5) st_n = 0;
         tick(1);
      end
   endtask
   task report_and_stop;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      #20000; mismatches++; report_and_stop;
   end
   initial begin
      tick(2); rstn = 1; tick(1);
      for (int m = 0; m < 4; m++) begin
         wr(12'(m) << 3); `CHK("input_mode", m[1:0], imode)
      end
      wr(12'h049);
      `CHK("range_2x", 1'b0, r2x)
      `CHK("chan_sel", 2'h2, chan)
      conv(12'hABC); `CHK("conv_cycles", 12, n)
      rd(rdata); `CHK("word", 12'hABC, rdata)
      wm = 0; rd(rdata); `CHK("low_byte", 8'hBC, rdata[7:0])
      hb = 1; rd(rdata); `CHK("high_byte", 6'h2A, rdata[5:0])
      wm = 1; hb = 0; wr(12'hA49);
      rd(rdata); `CHK("write_only", 12'hABC, rdata)
      conv(12'h123); rd(rdata); `CHK("twos", 12'h923, rdata)
      tick(2); `CHK("asleep", 1'b0, pwr)
      st_n = 1; tick(2); `CHK("awake", 1'b1, pwr)
      // sequencer over channels 0 and 1, wide input span
      wr(12'h026); `CHK("seq_first", 2'h0, chan)
      `CHK("range_wide", 1'b1, r2x)
      conv(12'h456); tick(1); `CHK("seq_next", 2'h1, chan)
      wm = 0; hb = 1; rd(rdata); `CHK("seq_id0", 6'h04, rdata[5:0])
      wm = 1; hb = 0; conv(12'h789); tick(1);
      `CHK("seq_wrap", 2'h0, chan)
      wm = 0; hb = 1; rd(rdata); `CHK("seq_id1", 6'h17, rdata[5:0])
      wm = 1; hb = 0;
      report_and_stop;
   end
endmodule
`default_nettype wire
